// ### atm_pkg.sv
// package: register map, field positions and carrier types of the aux timer
package atm_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CNT_LO = 3'h1;
    localparam logic [2:0] ADDR_CNT_HI = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_MASK = 3'h4;
    localparam logic [2:0] ADDR_COMP_CTRL = 3'h5;
    // control register fields
    localparam int BIT_WIDE = 7;
    localparam int BIT_CAP_HI = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_CAP_LO = 3;
    localparam int BIT_SYNC_DIS = 2;
    localparam int BIT_CLK_SRC = 1;
    localparam int BIT_RUN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // companion control register: oscillator enable
    localparam int BIT_OSC_EN = 0;
    // status / mask layout
    localparam int BIT_OVF = 0;
    localparam int BIT_TRIG = 1;
    // internal instruction clock = oscillator / 4
    localparam int INSTR_DIV = 4;
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } atm_req_t;

    // timebase routing towards the two capture/compare units
    typedef struct packed {
        logic unit1_uses_aux;
        logic unit2_uses_aux;
    } atm_route_t;
endpackage : atm_pkg

// ### atm_prescaler.sv
// module: edge-enable prescaler dividing by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module atm_prescaler #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [1:0] sel,
    output logic tick_out
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } atm_ps_state_t;

    atm_ps_state_t state;
    atm_ps_state_t next_state;
    logic [WIDTH-1:0] lim;

    // terminal value per code: 00 /1, 01 /2, 10 /4, 11 /8
    always_comb
    begin
        lim = WIDTH'((1 << sel) - 1);
        next_state = state;
        tick_out = tick_in && (state.cnt == lim);
        if (clear)
        begin
            next_state.cnt = '0;
        end
        else if (tick_in)
        begin
            next_state.cnt = (state.cnt == lim) ? '0 :
                             WIDTH'(state.cnt + 1'b1);
        end
    end

    // prescaler state
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state <= '0;
        else
            state <= next_state;
    end
endmodule : atm_prescaler
`default_nettype wire

// ### atm_edge_detect.sv
// module: external count input qualifier with optional synchroniser
`timescale 1ns/1ps
`default_nettype none
module atm_edge_detect (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic bypass_sync,
    input wire logic clk_in,
    output logic rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic last;
        logic armed;
    } atm_ed_state_t;

    atm_ed_state_t state;
    atm_ed_state_t next_state;
    logic sample;

    // bypass saves two cycles of latency but risks a metastable sample
    always_comb
    begin
        next_state = state;
        next_state.s1 = clk_in;
        next_state.s2 = state.s1;
        sample = bypass_sync ? clk_in : state.s2;
        next_state.last = sample;
        rise = 1'b0;
        if (!enable)
        begin
            next_state.armed = 1'b0;
        end
        else
        begin
            // only rises after a first seen fall are counted
            if (state.last && !sample)
                next_state.armed = 1'b1;
            rise = state.armed && !state.last && sample;
        end
    end

    // detector state
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state <= '0;
        else
            state <= next_state;
    end
endmodule : atm_edge_detect
`default_nettype wire

// ### atm_timer.sv
// module: 16-bit aux timer with register port, routing and interrupt
`timescale 1ns/1ps
`default_nettype none
module atm_timer #(
    parameter int INSTR_DIV = atm_pkg::INSTR_DIV
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic external_count_input,
    input wire logic companion_osc_in,
    input wire logic special_event_trigger,
    output logic unit1_uses_aux,
    output logic unit2_uses_aux,
    output logic irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } atm_mode_t;

    typedef struct packed {
        atm_mode_t mode;
        logic [7:0] ctrl;
        logic [7:0] comp_ctrl;
        logic [15:0] count;
        logic [7:0] hi_buf;
        logic [1:0] status;
        logic [1:0] mask;
        logic [1:0] div_cnt;
        logic [7:0] rdata;
    } atm_state_t;

    atm_state_t state;
    atm_state_t next_state;
    atm_pkg::atm_req_t req;
    atm_pkg::atm_route_t route;
    logic ext_sel;
    logic run;
    logic wide;
    logic instr_tick;
    logic ext_src;
    logic ext_rise;
    logic raw_tick;
    logic cnt_tick;
    logic [1:0] events;

    // byte-read decode used by the read mux
    function automatic logic [7:0] rd_mux(input atm_state_t s,
                                          input logic [2:0] a);
        begin
            case (a)
                atm_pkg::ADDR_CTRL: rd_mux = s.ctrl;
                atm_pkg::ADDR_CNT_LO: rd_mux = s.count[7:0];
                atm_pkg::ADDR_CNT_HI: rd_mux = s.ctrl[atm_pkg::BIT_WIDE] ?
                                               s.hi_buf : s.count[15:8];
                atm_pkg::ADDR_STATUS: rd_mux = {6'h00, s.status};
                atm_pkg::ADDR_MASK: rd_mux = {6'h00, s.mask};
                atm_pkg::ADDR_COMP_CTRL: rd_mux = s.comp_ctrl;
                default: rd_mux = atm_pkg::BYTE_ZERO;
            endcase
        end
    endfunction : rd_mux

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign run = state.ctrl[atm_pkg::BIT_RUN];
    assign wide = state.ctrl[atm_pkg::BIT_WIDE];
    assign ext_sel = state.ctrl[atm_pkg::BIT_CLK_SRC];

    // companion oscillator replaces the pin while it is enabled
    assign ext_src = state.comp_ctrl[atm_pkg::BIT_OSC_EN] ?
                     companion_osc_in : external_count_input;

    // instruction clock: one tick every four system clocks
    assign instr_tick = (state.div_cnt == 2'(INSTR_DIV - 1));

    // sync-disable only acts on the external path
    atm_edge_detect u_edge (
        .mclk(mclk),
        .resetn(resetn),
        .enable(ext_sel && run),
        .bypass_sync(state.ctrl[atm_pkg::BIT_SYNC_DIS]),
        .clk_in(ext_src),
        .rise(ext_rise)
    );

    assign raw_tick = run && (ext_sel ? ext_rise : instr_tick);

    atm_prescaler u_ps (
        .mclk(mclk),
        .resetn(resetn),
        .clear(!run),
        .tick_in(raw_tick),
        .sel(state.ctrl[atm_pkg::BIT_PS_HI:atm_pkg::BIT_PS_LO]),
        .tick_out(cnt_tick)
    );

    // timebase routing for the two capture/compare units
    always_comb
    begin
        route.unit1_uses_aux = state.ctrl[atm_pkg::BIT_CAP_HI];
        route.unit2_uses_aux = state.ctrl[atm_pkg::BIT_CAP_HI] ||
                               state.ctrl[atm_pkg::BIT_CAP_LO];
    end
    assign unit1_uses_aux = route.unit1_uses_aux;
    assign unit2_uses_aux = route.unit2_uses_aux;

    // level interrupt while any unmasked sticky bit is set
    assign irq = |(state.status & state.mask);

    // next-state: counter, register writes, reads, sticky flags
    always_comb
    begin
        next_state = state;
        events = 2'b00;
        next_state.rdata = atm_pkg::BYTE_ZERO;
        next_state.div_cnt = instr_tick ? 2'b00 : 2'(state.div_cnt + 2'b01);
        next_state.mode = run ? ST_RUN : ST_IDLE;
        case (state.mode)
            ST_RUN:
            begin
                if (cnt_tick)
                begin
                    next_state.count = state.count + 16'h0001;
                    if (state.count == atm_pkg::CNT_ALL_ONES)
                        events[atm_pkg::BIT_OVF] = 1'b1;
                end
            end
            ST_IDLE:
            begin
                next_state.count = state.count; // hold while stopped
            end
            default:
            begin
                next_state.mode = ST_IDLE;
            end
        endcase
        if (req.rd)
        begin
            next_state.rdata = rd_mux(state, req.addr);
            // wide-mode low read snapshots the high byte
            if (wide && req.addr == atm_pkg::ADDR_CNT_LO)
                next_state.hi_buf = state.count[15:8];
        end
        if (req.wr)
        begin
            case (req.addr)
                atm_pkg::ADDR_CTRL: next_state.ctrl = req.wdata;
                atm_pkg::ADDR_COMP_CTRL: next_state.comp_ctrl = req.wdata;
                atm_pkg::ADDR_MASK: next_state.mask = req.wdata[1:0];
                atm_pkg::ADDR_STATUS:
                    next_state.status = state.status & ~req.wdata[1:0];
                atm_pkg::ADDR_CNT_LO:
                begin
                    // wide: buffered high lands with the low byte
                    if (wide)
                        next_state.count = {state.hi_buf, req.wdata};
                    else
                        next_state.count[7:0] = req.wdata;
                end
                atm_pkg::ADDR_CNT_HI:
                begin
                    if (wide)
                        next_state.hi_buf = req.wdata;
                    else
                        next_state.count[15:8] = req.wdata;
                end
                default:
                begin
                    next_state.ctrl = state.ctrl;
                end
            endcase
        end
        // trigger comes last: it wins over an increment and a write
        if (special_event_trigger)
        begin
            next_state.count = atm_pkg::CNT_ZERO;
            events[atm_pkg::BIT_TRIG] = 1'b1;
        end
        // a set in the clear cycle wins
        next_state.status = next_state.status | events;
    end

    assign reg_rdata = state.rdata;

    // the single state register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= '0;
            state.mode <= ST_IDLE;
            state.ctrl <= atm_pkg::CTRL_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // named steps shared by the checks below
    // a counting tick at all ones, with no trigger or write beside it
    sequence seq_at_wrap;
        cnt_tick && run && !special_event_trigger && !req.wr &&
        state.mode == ST_RUN && state.count == atm_pkg::CNT_ALL_ONES;
    endsequence
    // the count is back at zero and the overflow flag is up
    sequence seq_wrapped;
        state.count == atm_pkg::CNT_ZERO && state.status[atm_pkg::BIT_OVF];
    endsequence
    // wide-mode high byte write, which only fills the buffer
    sequence seq_wide_hi_wr;
        wide && req.wr && req.addr == atm_pkg::ADDR_CNT_HI;
    endsequence
    // wide-mode low byte write with no trigger in the same cycle
    sequence seq_wide_lo_wr;
        wide && req.wr && req.addr == atm_pkg::ADDR_CNT_LO &&
        !special_event_trigger;
    endsequence
    // wide-mode low byte read, which snapshots the high byte
    sequence seq_wide_lo_rd;
        wide && req.rd && req.addr == atm_pkg::ADDR_CNT_LO;
    endsequence

    AST_OVF_FLAG: assert property (
        @(posedge mclk) disable iff (!resetn)
        seq_at_wrap |=> seq_wrapped)
        else $error("overflow not flagged");
    AST_OVF_SRC: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(state.status[atm_pkg::BIT_OVF]) |->
        $past(state.count) == atm_pkg::CNT_ALL_ONES)
        else $error("overflow flag without a wrap");
    AST_IRQ_OVF: assert property (
        @(posedge mclk) disable iff (!resetn)
        (state.status[atm_pkg::BIT_OVF] && state.mask[atm_pkg::BIT_OVF])
        |-> irq)
        else $error("unmasked overflow gives no interrupt");
    AST_TRIG_CLR: assert property (
        @(posedge mclk) disable iff (!resetn)
        special_event_trigger |=> state.count == atm_pkg::CNT_ZERO)
        else $error("trigger did not clear count");
    AST_TRIG_FLAG: assert property (
        @(posedge mclk) disable iff (!resetn)
        special_event_trigger |=> state.status[atm_pkg::BIT_TRIG])
        else $error("trigger not flagged");
    AST_HOLD: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!run && !special_event_trigger && !req.wr) |=> $stable(state.count))
        else $error("count moved while stopped");
    AST_INT_RATE: assert property (
        @(posedge mclk) disable iff (!resetn)
        (run && !ext_sel && raw_tick) |=> !raw_tick [*3])
        else $error("instruction tick too fast");
    AST_ROUTE: assert property (
        @(posedge mclk) disable iff (!resetn)
        unit1_uses_aux |-> unit2_uses_aux)
        else $error("routing code illegal");
    AST_INT_SRC: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!ext_sel) |-> !ext_rise)
        else $error("external edge on internal source");
    AST_EXT_ARM: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(ext_sel && run) |-> !ext_rise)
        else $error("edge counted before a fall was seen");
    AST_WIDE_RD: assert property (
        @(posedge mclk) disable iff (!resetn)
        seq_wide_lo_rd |=> state.hi_buf == $past(state.count[15:8]))
        else $error("high byte not buffered");
    AST_WIDE_HI: assert property (
        @(posedge mclk) disable iff (!resetn)
        seq_wide_hi_wr |=> state.hi_buf == $past(req.wdata))
        else $error("high byte write missed the buffer");
    AST_WIDE_WR: assert property (
        @(posedge mclk) disable iff (!resetn)
        seq_wide_lo_wr |=>
        state.count == {$past(state.hi_buf), $past(req.wdata)})
        else $error("wide write not coherent");
    AST_BYTE_WR: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!wide && req.wr && req.addr == atm_pkg::ADDR_CNT_HI &&
         !special_event_trigger) |=> state.count[15:8] == $past(req.wdata))
        else $error("byte write lost");
    AST_PS_DIV: assert property (
        @(posedge mclk) disable iff (!resetn)
        (state.ctrl[atm_pkg::BIT_PS_HI:atm_pkg::BIT_PS_LO] == 2'h1 &&
         $stable(state.ctrl) && cnt_tick) |-> !$past(cnt_tick))
        else $error("prescale by two broken");
    AST_RD_IDLE: assert property (
        @(posedge mclk) disable iff (!resetn)
        !req.rd |=> reg_rdata == atm_pkg::BYTE_ZERO)
        else $error("read data outside its cycle");
endmodule : atm_timer
`default_nettype wire

// ### atm_far_side.sv
// far-side model: count pin, companion oscillator and event trigger
`timescale 1ns/1ps
`default_nettype none
module atm_far_side (
    input wire logic mclk,
    output logic ext_pin,
    output logic osc_out,
    output logic trig
);
    // all lines idle low between bursts
    initial
    begin
        ext_pin = 1'b0;
        osc_out = 1'b0;
        trig = 1'b0;
    end

    // pulses stay 4 mclk high and 4 low, so the synchroniser never misses
    // one; the system clock never comes from this oscillator
    task automatic pulses(input logic sel, input int n);
        for (int i = 0; i < n; i++)
        begin
            ext_pin <= ~sel;
            osc_out <= sel;
            repeat (4) @(posedge mclk);
            ext_pin <= 1'b0;
            osc_out <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask : pulses

    // one-cycle special event from the capture/compare unit
    task automatic fire;
        trig <= 1'b1;
        @(posedge mclk);
        trig <= 1'b0;
        @(posedge mclk);
    endtask : fire
endmodule : atm_far_side
`default_nettype wire

// ### tb_top.sv
// testbench: register-port tests of the aux timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, resetn, reg_wr, reg_rd, irq, u1, u2, ext_pin, osc, trig;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    int num_errors = 0;
    int n_checks = 0;

    atm_timer dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_count_input(ext_pin),
        .companion_osc_in(osc), .special_event_trigger(trig),
        .unit1_uses_aux(u1), .unit2_uses_aux(u2), .irq(irq));
    atm_far_side partner (.mclk(mclk), .ext_pin(ext_pin), .osc_out(osc),
        .trig(trig));

    // 250 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // range compare; lo == hi makes it exact, unknowns never pass
    task automatic chk(input logic [7:0] got, input logic [7:0] lo,
        input logic [7:0] hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        n_checks++;
        if (ok !== 1'b1)
        begin
            $display("Error %0t got %h want %h..%h", $time, got, lo, hi);
            num_errors++;
        end
    endtask : chk

    // a gap cycle follows each strobe so it is never driven twice at once
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rdchk(input logic [2:0] a, input logic [7:0] lo,
        input logic [7:0] hi);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, lo, hi);
        @(posedge mclk);
    endtask : rdchk

    task automatic clr_count;
        wr(atm_pkg::ADDR_CTRL, 8'h00);
        wr(atm_pkg::ADDR_CNT_HI, 8'h00);
        wr(atm_pkg::ADDR_CNT_LO, 8'h00);
    endtask : clr_count

    // hang guard at 25000 cycles, far above the fewer than 900 cycles the tests take
    initial
    begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdchk(atm_pkg::ADDR_CTRL, 8'h00, 8'h00);
        wr(3'h6, 8'hff);
        rdchk(3'h6, 8'h00, 8'h00);
        // byte mode: direct bytes, held while stopped
        wr(atm_pkg::ADDR_CNT_HI, 8'h12);
        wr(atm_pkg::ADDR_CNT_LO, 8'h34);
        repeat (20) @(posedge mclk);
        rdchk(atm_pkg::ADDR_CNT_LO, 8'h34, 8'h34);
        rdchk(atm_pkg::ADDR_CNT_HI, 8'h12, 8'h12);
        // wide mode: a high write only fills the buffer
        wr(atm_pkg::ADDR_CTRL, 8'h80);
        wr(atm_pkg::ADDR_CNT_HI, 8'hab);
        wr(atm_pkg::ADDR_CTRL, 8'h00);
        rdchk(atm_pkg::ADDR_CNT_HI, 8'h12, 8'h12);
        wr(atm_pkg::ADDR_CTRL, 8'h80);
        wr(atm_pkg::ADDR_CNT_HI, 8'hab);
        wr(atm_pkg::ADDR_CNT_LO, 8'hcd);
        rdchk(atm_pkg::ADDR_CNT_LO, 8'hcd, 8'hcd);
        rdchk(atm_pkg::ADDR_CNT_HI, 8'hab, 8'hab);
        // overflow from all ones, then interrupt mask and clear
        wr(atm_pkg::ADDR_CTRL, 8'h00);
        wr(atm_pkg::ADDR_CNT_HI, 8'hff);
        wr(atm_pkg::ADDR_CNT_LO, 8'hfe);
        wr(atm_pkg::ADDR_CTRL, 8'h01);
        repeat (16) @(posedge mclk);
        wr(atm_pkg::ADDR_CTRL, 8'h00);
        rdchk(atm_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        rdchk(atm_pkg::ADDR_STATUS, 8'h01, 8'h01);
        chk({7'h00, irq}, 8'h00, 8'h00);
        wr(atm_pkg::ADDR_MASK, 8'h01);
        chk({7'h00, irq}, 8'h01, 8'h01);
        wr(atm_pkg::ADDR_STATUS, 8'h01);
        chk({7'h00, irq}, 8'h00, 8'h00);
        rdchk(atm_pkg::ADDR_STATUS, 8'h00, 8'h00);
        // special event clears the count
        wr(atm_pkg::ADDR_MASK, 8'h02);
        wr(atm_pkg::ADDR_CNT_HI, 8'h55);
        partner.fire();
        rdchk(atm_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        rdchk(atm_pkg::ADDR_STATUS, 8'h02, 8'h02);
        chk({7'h00, irq}, 8'h01, 8'h01);
        wr(atm_pkg::ADDR_STATUS, 8'h02);
        // capture source routing codes 00, 01, 10, 11
        for (int c = 0; c < 4; c++)
        begin
            wr(atm_pkg::ADDR_CTRL, {1'b0, c[1], 2'b00, c[0], 3'b000});
            chk({6'h00, u1, u2}, {6'h00, c[1], |c},
                {6'h00, c[1], |c});
        end
        // prescale codes over 128 mclk; sync-disable set must not matter
        for (int c = 0; c < 4; c++)
        begin
            clr_count();
            wr(atm_pkg::ADDR_CTRL, {2'b00, c[1:0], 4'h5});
            repeat (126) @(posedge mclk);
            wr(atm_pkg::ADDR_CTRL, 8'h00);
            d = 8'h20 >> c;
            rdchk(atm_pkg::ADDR_CNT_LO, d - 8'h02,
                  d + 8'h01);
        end
        // external pin, synchronised then raw: first rise is not counted
        for (int s = 0; s < 2; s++)
        begin
            clr_count();
            wr(atm_pkg::ADDR_CTRL, {5'h00, s[0], 2'b11});
            repeat (4) @(posedge mclk);
            partner.pulses(1'b0, 5);
            wr(atm_pkg::ADDR_CTRL, 8'h00);
            rdchk(atm_pkg::ADDR_CNT_LO, 8'h04, 8'h04);
        end
        // companion oscillator replaces the pin while enabled
        clr_count();
        wr(atm_pkg::ADDR_COMP_CTRL, 8'h01);
        wr(atm_pkg::ADDR_CTRL, 8'h03);
        repeat (4) @(posedge mclk);
        partner.pulses(1'b1, 5);
        partner.pulses(1'b0, 3);
        wr(atm_pkg::ADDR_CTRL, 8'h00);
        rdchk(atm_pkg::ADDR_CNT_LO, 8'h04, 8'h04);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
